// ===== include/timer_map.svh
// constants for the two-channel capture timer
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// counter geometry
`define COUNT_W 16
`define COUNT_MAX 16'hffff
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define CHANNELS 2

// reset value of every state bit (counter, values, flags, outputs)
`define STATE_RST '0

// nominal auxiliary clock rate, watch crystal or low-frequency oscillator
`define AUX_CLOCK_HZ 32768

// positions in the synchroniser vector
`define SYN_TCLK 0
`define SYN_AUX 1
`define SYN_SUB 2
`define SYN_ALT 3
`define SYN_CH0 4
`define SYN_CH1 5
`define SYN_CMP 6
`define SYN_W 7

// flag positions in the flag and clear vectors
`define FLG_CH0 0
`define FLG_CH1 1
`define FLG_OVF 2
`define FLG_W 3

// port bits that each channel output can reach
`define CH0_PORT_BITS 2
`define CH1_PORT_BITS 3

`endif

// ===== include/timer_pkg.sv
// types for the two-channel capture timer
`include "timer_map.svh"

package timer_pkg;

    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_AUX = 2'b01,
        SRC_SUB = 2'b10,
        SRC_ALT = 2'b11
    } clk_src_t;

    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_UP = 2'b01,
        MODE_CONT = 2'b10,
        MODE_UPDOWN = 2'b11
    } count_mode_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } cap_edge_t;

    typedef enum logic [1:0] {
        SEL_A = 2'b00,
        SEL_B = 2'b01,
        SEL_GND = 2'b10,
        SEL_VCC = 2'b11
    } cap_sel_t;

    typedef enum logic [2:0] {
        OUT_LEVEL = 3'b000,
        OUT_SET = 3'b001,
        OUT_TOG_RST = 3'b010,
        OUT_SET_RST = 3'b011,
        OUT_TOGGLE = 3'b100,
        OUT_RESET = 3'b101,
        OUT_TOG_SET = 3'b110,
        OUT_RST_SET = 3'b111
    } out_mode_t;

    typedef struct packed {
        logic capture_mode;
        cap_edge_t edge_sel;
        cap_sel_t in_sel;
        out_mode_t out_mode;
        logic out_bit;
        logic ie;
    } ch_cfg_t;

    typedef struct packed {
        clk_src_t clk_src;
        count_mode_t mode;
        logic ovf_ie;
        ch_cfg_t [`CHANNELS-1:0] ch;
    } timer_cfg_t;

    typedef struct packed {
        logic [`COUNT_W-1:0] value;
        logic flag;
        logic cap_ovf;
        logic cap_prev;
        logic out;
    } ch_state_t;

    typedef struct packed {
        logic [`SYN_W-1:0] sync1;
        logic [`SYN_W-1:0] sync2;
        logic clk_prev;
        logic [`COUNT_W-1:0] count;
        logic dir_down;
        logic ovf_flag;
        ch_state_t [`CHANNELS-1:0] ch;
    } state_t;

endpackage

// ===== hw/two_channel_capture_timer.sv
// 16-bit timer with two capture/compare channels, run from a selectable clock
//
// How it works
// - one 16-bit up or up/down counter, channels zero, one
// - overflow and per-channel events raise requests
// - each channel captures, compares, drives pwm output
// - timer clock from pin, auxiliary, submain or alternate external input
// - channel zero inputs: pin, aux, ground, supply
// - no comparator: channel one b is pin
// - with comparator: channel one b is comparator
// - channel zero own request; one, overflow shared
`include "timer_map.svh"

module two_channel_capture_timer #(
    parameter bit has_comparator = 1'b1
) (
    input wire logic clock_i,                         // system clock, 250 MHz
    input wire logic rst_b_i,                         // async reset, active low
    input wire logic ext_timer_clock_pin_i,           // external timer clock pin
    input wire logic aux_clock_i,                     // auxiliary clock
    input wire logic submain_clock_i,                 // sub-main clock
    input wire logic alt_ext_clock_input_i,           // alternate external clock
    input wire logic ch0_pin_i,                       // channel zero capture pin
    input wire logic ch1_pin_i,                       // channel one capture pin
    input wire logic comparator_output_i,             // analog comparator output
    input wire timer_pkg::timer_cfg_t cfg_i,          // mode and channel setup
    input wire logic count_clear_i,                   // clears counter and direction
    input wire logic [`CHANNELS-1:0] ch_load_i,       // load compare value strobe
    input wire logic [`COUNT_W-1:0] ch_load_data_i,   // compare value to load
    input wire logic [`FLG_W-1:0] flag_clear_i,       // clear flag strobes
    output logic [`COUNT_W-1:0] count_o,              // counter value
    output logic [`CHANNELS-1:0][`COUNT_W-1:0] ch_value_o, // channel values
    output logic [`FLG_W-1:0] flags_o,                // ovf, ch1, ch0 flags
    output logic [`CHANNELS-1:0] cap_overflow_o,      // capture overrun flags
    output logic irq_ch0_o,                           // channel zero request
    output logic irq_shared_o,                        // channel one or overflow
    output logic [`CH0_PORT_BITS-1:0] ch0_port_o,     // channel zero output
    output logic [`CH1_PORT_BITS-1:0] ch1_port_o      // channel one output
);
    import timer_pkg::*;

    // ==========================================================
    // state and input routing
    state_t st;
    state_t next_st;
    logic [`SYN_W-1:0] pins;
    logic [`CHANNELS-1:0] cap_a;
    logic [`CHANNELS-1:0] cap_b;
    logic [`CHANNELS-1:0] cap_in;
    logic clk_lvl;
    logic tick;

    // every pin and foreign clock is sampled, so sources must stay below half of clock_i
    assign pins = {comparator_output_i, ch1_pin_i, ch0_pin_i, alt_ext_clock_input_i,
                   submain_clock_i, aux_clock_i, ext_timer_clock_pin_i};

    genvar g;
    generate
        for (g = 0; g < `CHANNELS; g = g + 1) begin : g_cap
            assign cap_a[g] = st.sync2[`SYN_CH0 + g];
            if (g == 0) begin : g_b0
                assign cap_b[g] = st.sync2[`SYN_AUX];
            end else begin : g_b1
                assign cap_b[g] = has_comparator ? st.sync2[`SYN_CMP] : st.sync2[`SYN_CH1];
            end
            assign cap_in[g] = (cfg_i.ch[g].in_sel == SEL_A) ? cap_a[g] :
                               (cfg_i.ch[g].in_sel == SEL_B) ? cap_b[g] :
                               (cfg_i.ch[g].in_sel == SEL_VCC);
        end
    endgenerate

    // ==========================================================
    // timer clock selection
    // clock source mux
    always_comb begin
        unique case (cfg_i.clk_src)
            SRC_EXT: clk_lvl = st.sync2[`SYN_TCLK];
            SRC_AUX: clk_lvl = st.sync2[`SYN_AUX];
            SRC_SUB: clk_lvl = st.sync2[`SYN_SUB];
            SRC_ALT: clk_lvl = st.sync2[`SYN_ALT];
        endcase
    end

    assign tick = clk_lvl & ~st.clk_prev;

    // ==========================================================
    // output unit
    // own match acts after the period event so a channel's own edge wins
    function automatic logic apply_out(logic cur, out_mode_t m, logic own, logic period);
        logic o;
        o = cur;
        if (period) begin
            case (m)
                OUT_TOG_RST, OUT_SET_RST: o = 1'b0;
                OUT_TOG_SET, OUT_RST_SET: o = 1'b1;
                default: o = o;
            endcase
        end
        if (own) begin
            case (m)
                OUT_SET, OUT_SET_RST: o = 1'b1;
                OUT_TOG_RST, OUT_TOGGLE, OUT_TOG_SET: o = ~o;
                OUT_RESET, OUT_RST_SET: o = 1'b0;
                default: o = o;
            endcase
        end
        return o;
    endfunction

    // ==========================================================
    // next state
    logic [`COUNT_W-1:0] cnt_next;
    logic dir_next;
    logic wrap;
    logic counted;
    logic [`CHANNELS-1:0] hit;
    logic [`CHANNELS-1:0] rise;
    logic [`CHANNELS-1:0] fall;
    logic [`CHANNELS-1:0] cap_evt;
    logic [`CHANNELS-1:0] evt;
    logic [`CHANNELS-1:0] flag_clr;

    assign flag_clr = {flag_clear_i[`FLG_CH1], flag_clear_i[`FLG_CH0]};

    always_comb begin
        next_st = st;
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.clk_prev = clk_lvl;
        cnt_next = st.count;
        dir_next = st.dir_down;
        wrap = 1'b0;
        if (tick) begin
            unique case (cfg_i.mode)
                MODE_STOP: cnt_next = st.count;
                MODE_UP: begin
                    if (st.count >= st.ch[0].value) begin
                        cnt_next = `COUNT_ZERO;
                        wrap = 1'b1;
                    end else begin
                        cnt_next = st.count + `COUNT_ONE;
                    end
                end
                MODE_CONT: begin
                    cnt_next = st.count + `COUNT_ONE;
                    wrap = (st.count == `COUNT_MAX);
                end
                MODE_UPDOWN: begin
                    if (!st.dir_down) begin
                        if (st.count >= st.ch[0].value) begin
                            dir_next = 1'b1;
                            cnt_next = (st.count == `COUNT_ZERO) ? `COUNT_ZERO : st.count - `COUNT_ONE;
                        end else begin
                            cnt_next = st.count + `COUNT_ONE;
                        end
                    end else if (st.count <= `COUNT_ONE) begin
                        dir_next = 1'b0;
                        cnt_next = `COUNT_ZERO;
                        wrap = 1'b1;
                    end else begin
                        cnt_next = st.count - `COUNT_ONE;
                    end
                end
            endcase
        end
        counted = tick && (cfg_i.mode != MODE_STOP) && !count_clear_i;
        if (count_clear_i) begin
            cnt_next = `COUNT_ZERO;
            dir_next = 1'b0;
        end
        next_st.count = cnt_next;
        next_st.dir_down = dir_next;
        next_st.ovf_flag = (st.ovf_flag & ~flag_clear_i[`FLG_OVF]) | (wrap & counted);

        for (int i = 0; i < `CHANNELS; i++) begin
            hit[i] = counted && (cnt_next == st.ch[i].value);
            rise[i] = cap_in[i] & ~st.ch[i].cap_prev;
            fall[i] = ~cap_in[i] & st.ch[i].cap_prev;
        end

        for (int i = 0; i < `CHANNELS; i++) begin
            next_st.ch[i].cap_prev = cap_in[i];
            cap_evt[i] = cfg_i.ch[i].capture_mode &&
                         ((cfg_i.ch[i].edge_sel[0] && rise[i]) || (cfg_i.ch[i].edge_sel[1] && fall[i]));
            evt[i] = cfg_i.ch[i].capture_mode ? cap_evt[i] : hit[i];
            if (cap_evt[i]) begin
                next_st.ch[i].value = st.count;
            end else if (ch_load_i[i]) begin
                next_st.ch[i].value = ch_load_data_i;
            end
            // a second capture before the flag is cleared marks an overrun
            next_st.ch[i].cap_ovf = (st.ch[i].cap_ovf & ~flag_clr[i]) |
                                    (cap_evt[i] & st.ch[i].flag & ~flag_clr[i]);
            next_st.ch[i].flag = (st.ch[i].flag & ~flag_clr[i]) | evt[i];
            if (cfg_i.ch[i].out_mode == OUT_LEVEL) begin
                next_st.ch[i].out = cfg_i.ch[i].out_bit;
            end else if (!cfg_i.ch[i].capture_mode) begin
                next_st.ch[i].out = apply_out(st.ch[i].out, cfg_i.ch[i].out_mode, hit[i], hit[0]);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= `STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign count_o = st.count;
    assign flags_o = {st.ovf_flag, st.ch[1].flag, st.ch[0].flag};

    generate
        for (g = 0; g < `CHANNELS; g = g + 1) begin : g_out
            assign ch_value_o[g] = st.ch[g].value;
            assign cap_overflow_o[g] = st.ch[g].cap_ovf;
        end
    endgenerate

    assign irq_ch0_o = st.ch[0].flag & cfg_i.ch[0].ie;
    assign irq_shared_o = (st.ch[1].flag & cfg_i.ch[1].ie) | (st.ovf_flag & cfg_i.ovf_ie);

    assign ch0_port_o = {`CH0_PORT_BITS{st.ch[0].out}};
    assign ch1_port_o = {`CH1_PORT_BITS{st.ch[1].out}};

endmodule

// ===== verif/timer_partner.sv
// far-side model: timer clock sources and capture lines
module timer_partner (
    input wire logic clock_i,      // system clock
    input wire logic run_i,        // sources run while high
    input wire logic [2:0] lvl_i,  // ch0 pin, ch1 pin, comparator
    output logic [3:0] src_o,      // ext, aux, sub, alt
    output logic [2:0] pin_o       // capture lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div = 4'h0;
    // clocks stand still low outside a run
    always @(negedge clock_i) div <= run_i ? div + 4'h1 : 4'h0;
    assign src_o = {div[0], div[2], div[3], div[1]};
    assign pin_o = lvl_i;
endmodule

// ===== verif/timer_checker.sv
// port assertions for the capture timer
`include "timer_map.svh"
module timer_checker import timer_pkg::*; (
    input wire logic clock_i,                     // clock
    input wire logic rst_b_i,                     // reset
    input wire timer_pkg::timer_cfg_t cfg_i,      // setup
    input wire logic count_clear_i,               // clear
    input wire logic [`CHANNELS-1:0] ch_load_i,   // load
    input wire logic [`COUNT_W-1:0] ch_load_data_i, // load data
    input wire logic [`COUNT_W-1:0] count_o,      // counter
    input wire logic [`CHANNELS-1:0][`COUNT_W-1:0] ch_value_o, // values
    input wire logic [`FLG_W-1:0] flags_o,        // flags
    input wire logic irq_ch0_o,                   // ch0 request
    input wire logic irq_shared_o,                // shared request
    input wire logic [`CH0_PORT_BITS-1:0] ch0_port_o, // ch0 out
    input wire logic [`CH1_PORT_BITS-1:0] ch1_port_o  // ch1 out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_irq0_source: assert property (irq_ch0_o == (flags_o[0] & cfg_i.ch[0].ie))
        else $error("ch0 request mismatch");
    a_irq_shared_src: assert property (irq_shared_o ==
        ((flags_o[1] & cfg_i.ch[1].ie) | (flags_o[2] & cfg_i.ovf_ie))) else $error("shared request mismatch");
    a_ch0_fanout: assert property (ch0_port_o == {2{ch0_port_o[0]}})
        else $error("ch0 port bits differ");
    a_ch1_fanout: assert property (ch1_port_o == {3{ch1_port_o[0]}})
        else $error("ch1 port bits differ");
    a_stop_holds: assert property (cfg_i.mode == MODE_STOP && !count_clear_i |=> $stable(count_o))
        else $error("count moved while stopped");
    a_clear_zero: assert property (count_clear_i |=> count_o == 16'h0000)
        else $error("count not cleared");
    a_cont_step: assert property ($past(cfg_i.mode) == MODE_CONT && !$past(count_clear_i)
        && $changed(count_o) |-> count_o == $past(count_o) + 16'h0001) else $error("bad count step");
    a_up_wrap_ovf: assert property ($past(cfg_i.mode) == MODE_UP && !$past(count_clear_i)
        && $past(count_o) != 16'h0000 && count_o == 16'h0000 |-> flags_o[2]) else $error("wrap without flag");
    a_load_value: assert property (ch_load_i[1] && !cfg_i.ch[1].capture_mode
        |=> ch_value_o[1] == $past(ch_load_data_i)) else $error("load lost");
endmodule
bind two_channel_capture_timer timer_checker watch (.clock_i, .rst_b_i, .cfg_i, .count_clear_i, .ch_load_i,
    .ch_load_data_i, .count_o, .ch_value_o, .flags_o, .irq_ch0_o, .irq_shared_o, .ch0_port_o, .ch1_port_o);

// ===== verif/tb.sv
// self-checking bench for the capture timer
`include "timer_map.svh"
module tb import timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, rst_b_i = 1'b0, run = 1'b0, count_clear_i = 1'b0, prev = 1'b0;
    logic [2:0] lvl = 3'h0, flag_clear_i = 3'h0, pin, flags_o, flags_nc, ch1_port_o;
    logic [1:0] ch_load_i = 2'h0, ch0_port_o, cap_ovf;
    logic [15:0] ch_load_data_i = 16'h0000, count_o;
    logic [1:0][15:0] ch_value_o;
    logic [3:0] src;
    logic irq_ch0_o, irq_shared_o;
    timer_cfg_t cfg_i = '0;
    int error_cnt = 0, samples_checked = 0, ticks = 0;
    always #2 clock_i = ~clock_i;
    timer_partner far (.clock_i, .run_i(run), .lvl_i(lvl), .src_o(src), .pin_o(pin));
    two_channel_capture_timer dut (.clock_i, .rst_b_i, .ext_timer_clock_pin_i(src[0]), .aux_clock_i(src[1]),
        .submain_clock_i(src[2]), .alt_ext_clock_input_i(src[3]), .ch0_pin_i(pin[0]), .ch1_pin_i(pin[1]),
        .comparator_output_i(pin[2]), .cfg_i, .count_clear_i, .ch_load_i, .ch_load_data_i, .flag_clear_i,
        .count_o, .ch_value_o, .flags_o, .cap_overflow_o(cap_ovf), .irq_ch0_o, .irq_shared_o, .ch0_port_o,
        .ch1_port_o);
    two_channel_capture_timer #(.has_comparator(1'b0)) dut_nc (.clock_i, .rst_b_i,
        .ext_timer_clock_pin_i(src[0]), .aux_clock_i(src[1]), .submain_clock_i(src[2]),
        .alt_ext_clock_input_i(src[3]), .ch0_pin_i(pin[0]), .ch1_pin_i(pin[1]), .comparator_output_i(pin[2]),
        .cfg_i, .count_clear_i, .ch_load_i, .ch_load_data_i, .flag_clear_i, .count_o(), .ch_value_o(),
        .flags_o(flags_nc), .cap_overflow_o(), .irq_ch0_o(), .irq_shared_o(), .ch0_port_o(), .ch1_port_o());
    // ==========================================
    // reference model: rising edges of the chosen source
    always @(posedge clock_i) begin
        if (cfg_i.mode != MODE_STOP && !count_clear_i && src[cfg_i.clk_src] && !prev) ticks++;
        prev = src[cfg_i.clk_src];
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic clr();
        count_clear_i = 1'b1;
        flag_clear_i = 3'h7;
        cyc(1);
        flag_clear_i = 3'h0;
        cyc(3);
        count_clear_i = 1'b0;
        ticks = 0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // hang guard
    initial begin
        #400000;
        error_cnt++;
        test_done();
    end
    // ==========================================
    // main sequence
    initial begin
        int n, t, ce, m, p, cv;
        logic ob, e, o;
        void'($urandom(32'haa45733c));
        cyc(20);
        rst_b_i = 1'b1;
        cyc(2);
        for (int s = 0; s < 4; s++) begin
            cfg_i.clk_src = clk_src_t'(s);
            cfg_i.mode = MODE_CONT;
            clr();
            run = 1'b1;
            cyc(40 + s);
            run = 1'b0;
            cyc(6);
            chk("count", ticks[15:0], count_o);
        end
        $display("test source select done");
        n = 3 + $urandom % 6;
        ob = 1'($urandom % 2);
        cfg_i.clk_src = SRC_ALT;
        cfg_i.mode = MODE_UP;
        cfg_i.ovf_ie = 1'b1;
        cfg_i.ch[0].out_mode = OUT_TOGGLE;
        cfg_i.ch[0].ie = 1'b1;
        cfg_i.ch[1].out_bit = ob;
        ch_load_data_i = n[15:0];
        ch_load_i = 2'b11;
        cyc(1);
        ch_load_i = 2'b00;
        clr();
        run = 1'b1;
        cyc(16 + $urandom % 40);
        run = 1'b0;
        cyc(6);
        t = ticks;
        ce = t % (n + 1);
        chk("count", ce[15:0], count_o);
        chk("flags", {t > n, t >= n, t >= n}, flags_o);
        chk("irq shared", t > n, irq_shared_o);
        chk("irq ch0", t >= n, irq_ch0_o);
        chk("ch0 port", {2{((t + 1) / (n + 1)) % 2 == 1}}, ch0_port_o);
        chk("ch1 port", {3{ob}}, ch1_port_o);
        flag_clear_i = 3'b101;
        cyc(1);
        flag_clear_i = 3'h0;
        cyc(1);
        chk("flags cleared", {1'b0, t >= n, 1'b0}, flags_o);
        chk("irq ch0", 16'h0000, irq_ch0_o);
        $display("test interval done");
        cfg_i.mode = MODE_STOP;
        for (int c = 0; c < 2; c++) begin
            cfg_i.ch[c].capture_mode = 1'b1;
            cfg_i.ch[c].edge_sel = EDGE_RISE;
            // line 3 stands for the auxiliary clock
            for (int s = 0; s < 2; s++) for (int l = 0; l < 4; l++) begin
                cfg_i.ch[c].in_sel = cap_sel_t'(s);
                cyc(6);
                flag_clear_i = 3'h3;
                cyc(1);
                flag_clear_i = 3'h0;
                if (l == 3) run = 1'b1;
                else lvl[l] = 1'b1;
                cyc(20);
                run = 1'b0;
                lvl = 3'h0;
                cyc(6);
                e = (l == (s ? 3 - c : c));
                chk("capture flag", e, flags_o[c]);
                if (e) chk("capture value", ce[15:0], ch_value_o[c]);
                if (c == 1) chk("no comparator flag", l == 1, flags_nc[1]);
            end
            cfg_i.ch[c].in_sel = SEL_GND;
            cyc(6);
            flag_clear_i = 3'h3;
            cyc(1);
            flag_clear_i = 3'h0;
            cfg_i.ch[c].in_sel = SEL_VCC;
            cyc(4);
            chk("soft capture", 16'h0001, flags_o[c]);
            chk("no overrun", 16'h0000, cap_ovf[c]);
            // a falling edge while the flag still stands is an overrun
            cfg_i.ch[c].edge_sel = cap_edge_t'(2 + c);
            cfg_i.ch[c].in_sel = SEL_GND;
            cyc(4);
            chk("overrun", 16'h0001, cap_ovf[c]);
        end
        $display("test capture inputs done");
        m = 1 + $urandom % (n - 1);
        cfg_i.mode = MODE_UPDOWN;
        cfg_i.ch[0].capture_mode = 1'b0;
        cfg_i.ch[1].capture_mode = 1'b0;
        cfg_i.ch[1].ie = 1'b1;
        ch_load_data_i = n[15:0];
        ch_load_i = 2'b01;
        cyc(1);
        ch_load_data_i = m[15:0];
        ch_load_i = 2'b10;
        cyc(1);
        ch_load_i = 2'b00;
        for (int md = 1; md < 8; md++) begin
            cfg_i.ch[1].out_mode = OUT_LEVEL;
            cyc(1);
            cfg_i.ch[1].out_mode = out_mode_t'(md);
            clr();
            run = 1'b1;
            cyc(16 + $urandom % 40);
            run = 1'b0;
            cyc(6);
            t = ticks;
            o = ob;
            // period event first, then the channel's own match
            for (int k = 1; k <= t; k++) begin
                p = k % (2 * n);
                cv = (p <= n) ? p : 2 * n - p;
                if (cv == n && md inside {2, 3}) o = 1'b0;
                if (cv == n && md inside {6, 7}) o = 1'b1;
                if (cv == m) o = (md inside {1, 3}) ? 1'b1 : (md inside {5, 7}) ? 1'b0 : ~o;
            end
            p = t % (2 * n);
            cv = (p <= n) ? p : 2 * n - p;
            chk("updown count", cv[15:0], count_o);
            chk("updown flags", {t >= 2 * n, t >= m, t >= n}, flags_o);
            chk("irq shared ch1", t >= m, irq_shared_o);
            chk("ch1 pwm port", {3{o}}, ch1_port_o);
        end
        $display("test output modes done");
        test_done();
    end
endmodule
